/* shared/cpp_pkg.sv */
package cpp_pkg;
  // event kinds posted from the link domain
  typedef enum logic [1:0]
  {
    CPP_EV_HDR_WR = 2'b00,
    CPP_EV_HDR_RD = 2'b01,
    CPP_EV_WR_BYTE = 2'b10,
    CPP_EV_RD_NEXT = 2'b11
  } cpp_ev_kind_t;
  // event word held stable across the crossing
  typedef struct packed
  {
    cpp_ev_kind_t kind;
    logic [15:0] data;
  } cpp_ev_t;
  // command header seen by the core
  typedef struct packed
  {
    logic from_spi;
    logic is_read;
    logic [15:0] addr;
  } cpp_cmd_t;
  // i2c target states
  typedef enum logic [2:0]
  {
    CPP_I2C_IDLE = 3'b000,
    CPP_I2C_ADDR = 3'b001,
    CPP_I2C_ACK = 3'b010,
    CPP_I2C_RX = 3'b011,
    CPP_I2C_TX = 3'b100,
    CPP_I2C_TX_ACK = 3'b101
  } cpp_i2c_state_t;
endpackage

/* shared/cpp_regs.svh */
`ifndef CPP_REGS_SVH
`define CPP_REGS_SVH
// spi frame layout, byte index counted from latch fall
`define CPP_SPI_BYTE_CHIP 3'd0
`define CPP_SPI_BYTE_AHI 3'd1
`define CPP_SPI_BYTE_ALO 3'd2
`define CPP_SPI_BYTE_TURN 3'd3
`define CPP_SPI_BYTE_DATA 3'd4
// bit positions inside one spi byte
`define CPP_SPI_BIT_LAST 3'd7
`define CPP_SPI_BIT_LOAD 3'd0
`define CPP_SPI_BIT_POST 3'd3
// i2c bit counter
`define CPP_I2C_BITS 4'd8
// i2c byte index inside a write
`define CPP_I2C_IDX_AHI 2'd0
`define CPP_I2C_IDX_ALO 2'd1
`define CPP_I2C_IDX_DATA 2'd2
// address step
`define CPP_ADDR_STEP 16'h0001
`endif

/* src/cpp_control_port.sv */
`timescale 1ns/10ps
`include "cpp_regs.svh"
module cpp_control_port #(
  parameter logic [4:0] I2C_ADDR_BASE = 5'h00,
  parameter logic [5:0] SPI_CHIP_BASE = 6'h00
)(
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic core_clk_en,
  // mode select from core logic
  input wire logic port_spi_mode,
  // control port pins
  input wire logic addr_select_lo,
  input wire logic spi_latch_n,
  input wire logic spi_serial_clock,
  input wire logic spi_data_in,
  input wire logic boot_from_eeprom_sel,
  input wire logic ctl_data_in,
  output logic ctl_data_out,
  output logic ctl_data_oe,
  output logic ctl_clock_out,
  output logic ctl_clock_oe,
  // self-boot engine side
  input wire logic boot_scl_low,
  input wire logic boot_sda_low,
  output logic boot_mode,
  output logic boot_start,
  // core access side
  output cpp_pkg::cpp_cmd_t cmd,
  output logic cmd_valid,
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_req,
  output logic [15:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic spi_frame_active
);
  import cpp_pkg::*;

  // ----------------------------------------------------------
  // link domain: spi target on the serial clock
  // ----------------------------------------------------------
  logic [2:0] sbit_reg; // bit within byte
  logic [6:0] srx_reg; // receive shift
  logic [2:0] sbyte_reg; // byte index, saturates at data
  logic ssel_reg; // this device addressed
  logic srw_reg; // read transaction
  logic [7:0] sahi_reg; // sub address high byte
  logic slo_s1, slo_s2; // low select pin sync
  logic ev_tgl_reg; // event toggle toward core
  cpp_ev_t ev_reg; // event payload, stable per toggle
  logic [7:0] stx_reg; // transmit shift
  logic soe_reg; // spi output enable
  logic [7:0] rd_hold_reg; // prefetched read byte, core domain
  logic [7:0] sbyte_in; // byte completing this edge
  logic sbyte_done; // last bit of a byte

  assign sbyte_in = {srx_reg, spi_data_in};
  assign sbyte_done = (sbit_reg == `CPP_SPI_BIT_LAST);

  // bit counter and shifter, cleared by latch high
  always_ff @(posedge spi_serial_clock or posedge spi_latch_n)
  begin
    if (spi_latch_n)
    begin
      sbit_reg <= 3'h0;
      srx_reg <= 7'h00;
    end
    else
    begin
      sbit_reg <= sbit_reg + 3'h1;
      srx_reg <= sbyte_in[6:0];
    end
  end

  // low select pin strap, two stages on the link clock
  always_ff @(posedge spi_serial_clock or posedge spi_latch_n)
  begin
    if (spi_latch_n)
    begin
      slo_s1 <= 1'b0;
      slo_s2 <= 1'b0;
    end
    else
    begin
      slo_s1 <= addr_select_lo;
      slo_s2 <= slo_s1;
    end
  end

  // header decode: chip match, direction, sub address
  always_ff @(posedge spi_serial_clock or posedge spi_latch_n)
  begin
    if (spi_latch_n)
    begin
      sbyte_reg <= `CPP_SPI_BYTE_CHIP;
      ssel_reg <= 1'b0;
      srw_reg <= 1'b0;
      sahi_reg <= 8'h00;
    end
    else if (sbyte_done)
    begin
      // advance byte index until the data phase
      if (sbyte_reg != `CPP_SPI_BYTE_DATA)
      begin
        sbyte_reg <= sbyte_reg + 3'h1;
      end
      case (sbyte_reg)
        `CPP_SPI_BYTE_CHIP:
        begin
          ssel_reg <= (sbyte_in[7:1] == {SPI_CHIP_BASE, slo_s2});
          srw_reg <= sbyte_in[0];
        end
        `CPP_SPI_BYTE_AHI:
        begin
          sahi_reg <= sbyte_in;
        end
        default:
        begin
          sahi_reg <= sahi_reg;
        end
      endcase
    end
  end

  // event posting: header, write bytes, read consumption
  // core reset only: a latch rise must not flip the toggle, or the core
  // would see a phantom event after every frame with an odd event count
  // next state equals state while the latch is high, so the release of
  // reset is harmless even against a running link clock
  always_ff @(posedge spi_serial_clock or posedge reset)
  begin
    if (reset)
    begin
      ev_tgl_reg <= 1'b0;
      ev_reg <= '0;
    end
    else if (ssel_reg)
    begin
      // header done after the low address byte
      if (sbyte_done && sbyte_reg == `CPP_SPI_BYTE_ALO)
      begin
        ev_tgl_reg <= ~ev_tgl_reg;
        ev_reg.kind <= srw_reg ? CPP_EV_HDR_RD : CPP_EV_HDR_WR;
        ev_reg.data <= {sahi_reg, sbyte_in};
      end
      // writes carry data from the byte after the header
      else if (sbyte_done && !srw_reg && sbyte_reg >= `CPP_SPI_BYTE_TURN)
      begin
        ev_tgl_reg <= ~ev_tgl_reg;
        ev_reg.kind <= CPP_EV_WR_BYTE;
        ev_reg.data <= {8'h00, sbyte_in};
      end
      // reads ask for the next byte mid-way through each one
      else if (srw_reg && sbyte_reg == `CPP_SPI_BYTE_DATA && sbit_reg == `CPP_SPI_BIT_POST)
      begin
        ev_tgl_reg <= ~ev_tgl_reg;
        ev_reg.kind <= CPP_EV_RD_NEXT;
        ev_reg.data <= 16'h0000;
      end
    end
  end

  // read-back shifter on the falling edge, after a turnaround byte
  always_ff @(negedge spi_serial_clock or posedge spi_latch_n)
  begin
    if (spi_latch_n)
    begin
      stx_reg <= 8'h00;
      soe_reg <= 1'b0;
    end
    else if (ssel_reg && srw_reg && sbyte_reg == `CPP_SPI_BYTE_DATA
             && sbit_reg == `CPP_SPI_BIT_LOAD)
    begin
      // rd_hold_reg settled several link cycles before this edge
      stx_reg <= rd_hold_reg;
      soe_reg <= 1'b1;
    end
    else
    begin
      stx_reg <= {stx_reg[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------
  // core domain: synchronisers
  // ----------------------------------------------------------
  logic ev_s1, ev_s2, ev_s3; // event toggle sync
  logic lat_s1, lat_s2; // latch sync
  logic scl_s1, scl_s2, scl_s3; // i2c clock sync
  logic sda_s1, sda_s2, sda_s3; // i2c data sync
  logic ahi_s1, ahi_s2; // high select sync
  logic alo_s1, alo_s2; // low select sync
  logic bsel_s1, bsel_s2; // boot select sync
  logic ev_pulse; // new link event

  // two stages per pin, third stage only for edges
  always_ff @(posedge core_clk)
  begin
    if (core_clk_en)
    begin
      ev_s1 <= ev_tgl_reg;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      lat_s1 <= spi_latch_n;
      lat_s2 <= lat_s1;
      scl_s1 <= spi_serial_clock;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= ctl_data_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      ahi_s1 <= spi_data_in;
      ahi_s2 <= ahi_s1;
      alo_s1 <= addr_select_lo;
      alo_s2 <= alo_s1;
      bsel_s1 <= boot_from_eeprom_sel;
      bsel_s2 <= bsel_s1;
    end
  end

  assign ev_pulse = port_spi_mode && (ev_s2 ^ ev_s3);

  // frame flag for the core
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      spi_frame_active <= 1'b0;
    end
    else if (core_clk_en)
    begin
      spi_frame_active <= port_spi_mode && !lat_s2;
    end
  end

  // ----------------------------------------------------------
  // self-boot capture at reset release
  // ----------------------------------------------------------
  logic boot_armed_reg; // first cycle after reset

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      boot_armed_reg <= 1'b1;
      boot_mode <= 1'b0;
      boot_start <= 1'b0;
    end
    else if (core_clk_en)
    begin
      boot_start <= boot_armed_reg && bsel_s2;
      if (boot_armed_reg)
      begin
        boot_mode <= bsel_s2;
        boot_armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // i2c target on sampled pins
  // ----------------------------------------------------------
  cpp_i2c_state_t ist_reg; // target state
  logic [3:0] icnt_reg; // bits this byte
  logic [7:0] ish_reg; // byte shifter
  logic ird_reg; // read direction
  logic [1:0] iidx_reg; // write byte index
  logic [7:0] iahi_reg; // sub address high byte
  logic isda_low_reg; // pull data low
  logic i_hdr, i_wr, i_fetch; // strobes to access logic
  logic i_en, i_start, i_stop, i_rise, i_fall;

  assign i_en = !port_spi_mode && !boot_mode;
  assign i_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign i_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign i_rise = scl_s2 && !scl_s3;
  assign i_fall = !scl_s2 && scl_s3;

  // byte level target state machine
  always_ff @(posedge core_clk)
  begin
    if (reset || !i_en)
    begin
      ist_reg <= CPP_I2C_IDLE;
      icnt_reg <= 4'h0;
      ish_reg <= 8'h00;
      ird_reg <= 1'b0;
      iidx_reg <= `CPP_I2C_IDX_AHI;
      iahi_reg <= 8'h00;
      isda_low_reg <= 1'b0;
      i_hdr <= 1'b0;
      i_wr <= 1'b0;
      i_fetch <= 1'b0;
    end
    else if (core_clk_en)
    begin
      i_hdr <= 1'b0;
      i_wr <= 1'b0;
      i_fetch <= 1'b0;
      if (i_start)
      begin
        // start or repeated start
        ist_reg <= CPP_I2C_ADDR;
        icnt_reg <= 4'h0;
        iidx_reg <= `CPP_I2C_IDX_AHI;
        isda_low_reg <= 1'b0;
      end
      else if (i_stop)
      begin
        ist_reg <= CPP_I2C_IDLE;
        isda_low_reg <= 1'b0;
      end
      else
      begin
        case (ist_reg)
          CPP_I2C_ADDR, CPP_I2C_RX:
          begin
            // sample on rise, act on the fall after eight bits
            if (i_rise && icnt_reg != `CPP_I2C_BITS)
            begin
              ish_reg <= {ish_reg[6:0], sda_s2};
              icnt_reg <= icnt_reg + 4'h1;
            end
            else if (i_fall && icnt_reg == `CPP_I2C_BITS)
            begin
              icnt_reg <= 4'h0;
              if (ist_reg == CPP_I2C_RX)
              begin
                isda_low_reg <= 1'b1;
                ist_reg <= CPP_I2C_ACK;
                i_hdr <= (iidx_reg == `CPP_I2C_IDX_ALO);
                i_wr <= (iidx_reg == `CPP_I2C_IDX_DATA);
                if (iidx_reg == `CPP_I2C_IDX_AHI)
                begin
                  iahi_reg <= ish_reg;
                end
                if (iidx_reg != `CPP_I2C_IDX_DATA)
                begin
                  iidx_reg <= iidx_reg + 2'h1;
                end
              end
              else if (ish_reg[7:1] == {I2C_ADDR_BASE, ahi_s2, alo_s2})
              begin
                isda_low_reg <= 1'b1;
                ird_reg <= ish_reg[0];
                i_fetch <= ish_reg[0];
                ist_reg <= CPP_I2C_ACK;
              end
              else
              begin
                ist_reg <= CPP_I2C_IDLE;
              end
            end
          end
          CPP_I2C_ACK, CPP_I2C_TX_ACK:
          begin
            // master nack ends a read
            if (ist_reg == CPP_I2C_TX_ACK && i_rise && sda_s2)
            begin
              ist_reg <= CPP_I2C_IDLE;
            end
            else if (i_fall)
            begin
              icnt_reg <= 4'h0;
              if (ird_reg)
              begin
                ish_reg <= rd_hold_reg;
                isda_low_reg <= !rd_hold_reg[7];
                i_fetch <= 1'b1;
                ist_reg <= CPP_I2C_TX;
              end
              else
              begin
                isda_low_reg <= 1'b0;
                ist_reg <= CPP_I2C_RX;
              end
            end
          end
          CPP_I2C_TX:
          begin
            if (i_rise)
            begin
              icnt_reg <= icnt_reg + 4'h1;
            end
            else if (i_fall && icnt_reg == `CPP_I2C_BITS)
            begin
              isda_low_reg <= 1'b0;
              ist_reg <= CPP_I2C_TX_ACK;
            end
            else if (i_fall)
            begin
              ish_reg <= {ish_reg[6:0], 1'b0};
              isda_low_reg <= !ish_reg[6];
            end
          end
          default:
          begin
            isda_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // access side shared by both modes
  // ----------------------------------------------------------
  logic c_hdr, c_rd, c_wr, c_fetch; // merged strobes
  logic [15:0] c_addr; // header address
  logic [7:0] c_byte; // write byte
  logic [15:0] addr_reg; // running address

  always_comb
  begin
    c_hdr = i_hdr || (ev_pulse && (ev_reg.kind == CPP_EV_HDR_WR || ev_reg.kind == CPP_EV_HDR_RD));
    c_rd = ev_pulse && ev_reg.kind == CPP_EV_HDR_RD;
    c_wr = i_wr || (ev_pulse && ev_reg.kind == CPP_EV_WR_BYTE);
    c_fetch = i_fetch || (ev_pulse && ev_reg.kind == CPP_EV_RD_NEXT);
    c_addr = port_spi_mode ? ev_reg.data : {iahi_reg, ish_reg};
    c_byte = port_spi_mode ? ev_reg.data[7:0] : ish_reg;
  end

  // command, write and read strobes with auto increment
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cmd <= '0;
      cmd_valid <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 8'h00;
      rd_req <= 1'b0;
      rd_addr <= 16'h0000;
      addr_reg <= 16'h0000;
    end
    else if (core_clk_en)
    begin
      cmd_valid <= c_hdr;
      wr_valid <= c_wr;
      rd_req <= c_rd || c_fetch;
      if (c_hdr)
      begin
        cmd <= '{from_spi: port_spi_mode, is_read: c_rd, addr: c_addr};
        rd_addr <= c_addr;
        addr_reg <= c_rd ? c_addr + `CPP_ADDR_STEP : c_addr;
      end
      else if (c_wr)
      begin
        wr_addr <= addr_reg;
        wr_data <= c_byte;
        addr_reg <= addr_reg + `CPP_ADDR_STEP;
      end
      else if (c_fetch)
      begin
        rd_addr <= addr_reg;
        addr_reg <= addr_reg + `CPP_ADDR_STEP;
      end
    end
  end

  // read byte captured while rd_req is high
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rd_hold_reg <= 8'h00;
    end
    else if (core_clk_en && rd_req)
    begin
      rd_hold_reg <= rd_data;
    end
  end

  // ----------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctl_clock_oe <= 1'b0;
    end
    else if (core_clk_en)
    begin
      ctl_clock_oe <= boot_mode && boot_scl_low;
    end
  end

  assign ctl_clock_out = 1'b0;
  assign ctl_data_out = port_spi_mode ? stx_reg[7] : 1'b0;
  assign ctl_data_oe = port_spi_mode ? soe_reg
                     : (boot_mode ? boot_sda_low : isda_low_reg);
endmodule

/* tb/control_port_pin_interface_tb.sv */
`timescale 1ns/10ps
module control_port_pin_interface_tb;
  import cpp_pkg::*;
  // core-side stimulus
  logic core_clk, reset, port_spi_mode, addr_select_lo, boot_from_eeprom_sel;
  logic boot_scl_low, boot_sda_low;
  // pins and outputs
  logic spi_latch_n, spi_serial_clock, spi_data_in, host_sda_low, sda_wire;
  logic ctl_data_out, ctl_data_oe, ctl_clock_out, ctl_clock_oe, boot_mode, boot_start;
  logic cmd_valid, wr_valid, rd_req, spi_frame_active;
  cpp_cmd_t cmd;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data;
  int miscompares = 0, check_count = 0, cycles = 0;
  logic [17:0] cmd_q[$];
  logic [23:0] wr_q[$];
  // shared wire with pull-up
  assign sda_wire = (ctl_data_oe ? ctl_data_out : 1'b1) & ~host_sda_low;
  // memory answers with address pattern
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  cpp_control_port i_dut (.core_clk(core_clk), .reset(reset), .core_clk_en(1'b1),
    .port_spi_mode(port_spi_mode), .addr_select_lo(addr_select_lo), .spi_latch_n(spi_latch_n),
    .spi_serial_clock(spi_serial_clock), .spi_data_in(spi_data_in),
    .boot_from_eeprom_sel(boot_from_eeprom_sel), .ctl_data_in(sda_wire),
    .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe), .ctl_clock_out(ctl_clock_out),
    .ctl_clock_oe(ctl_clock_oe), .boot_scl_low(boot_scl_low), .boot_sda_low(boot_sda_low),
    .boot_mode(boot_mode), .boot_start(boot_start), .cmd(cmd), .cmd_valid(cmd_valid),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .spi_frame_active(spi_frame_active));
  cpp_host_model i_host (.spi_latch_n(spi_latch_n), .spi_serial_clock(spi_serial_clock),
    .spi_data_in(spi_data_in), .host_sda_low(host_sda_low), .sda_wire(sda_wire));
  // ---------------------------
  // clock, capture, timeout
  // ---------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (cmd_valid === 1'b1) cmd_q.push_back(cmd);
    if (wr_valid === 1'b1) wr_q.push_back({wr_addr, wr_data});
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end
  // ---------------------------
  // helpers
  // ---------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // reset for ten cycles, count boot pulses after release
  task automatic do_reset(input logic boot);
    logic [3:0] pulses;
    pulses = 4'h0;
    @(posedge core_clk);
    reset <= 1'b1;
    boot_from_eeprom_sel <= boot;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4)
    begin
      @(posedge core_clk);
      #1 pulses = pulses + boot_start;
    end
    check(pulses, boot);
    check(boot_mode, boot);
  endtask
  // one spi frame with fresh capture queues
  task automatic spi_run(input int nbits, input bit free, input logic [63:0] tx,
                         output logic [63:0] rx);
    @(posedge core_clk);
    cmd_q.delete();
    wr_q.delete();
    i_host.spi_xfer(nbits, free, tx, rx);
    #120;
  endtask
  // ---------------------------
  // scenarios
  // ---------------------------
  task automatic t_boot;
    do_reset(1'b1);
    boot_scl_low <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(ctl_clock_oe, 1'b1);
    check(ctl_clock_out, 1'b0);
    do_reset(1'b0);
    repeat (2) @(posedge core_clk);
    check(ctl_clock_oe, 1'b0);
    boot_scl_low <= 1'b0;
  endtask
  // write across a 256 boundary, header after an aborted frame
  task automatic t_spi_write;
    logic [63:0] rx;
    port_spi_mode <= 1'b1;
    addr_select_lo <= 1'b1;
    spi_run(12, 1'b0, {8'h02, 8'hff, 48'h0}, rx);
    check(cmd_q.size(), 0);
    spi_run(40, 1'b1, {8'h02, 16'h12ff, 8'ha5, 8'h3c, 24'h0}, rx);
    check(cmd_q.size(), 1);
    check(cmd_q[0], {1'b1, 1'b0, 16'h12ff});
    check(wr_q.size(), 2);
    check(wr_q[0], {16'h12ff, 8'ha5});
    check(wr_q[1], {16'h1300, 8'h3c});
  endtask
  // two-byte read, then a read to the other chip
  task automatic t_spi_read;
    logic [63:0] rx;
    spi_run(48, 1'b1, {8'h03, 16'h0040, 8'h00, 16'h0, 16'h0}, rx);
    check(cmd_q.size(), 1);
    check(cmd_q[0], {1'b1, 1'b1, 16'h0040});
    check(rx[15:0], 16'h1a1b);
    check(ctl_data_oe, 1'b0);
    addr_select_lo <= 1'b0;
    spi_run(48, 1'b0, {8'h03, 16'h0040, 8'h00, 16'h0, 16'h0}, rx);
    check(cmd_q.size(), 0);
    check(rx[15:0], 16'hffff);
  endtask
  // i2c address built from both select pins
  task automatic t_i2c;
    logic ack;
    port_spi_mode <= 1'b0;
    addr_select_lo <= 1'b1;
    @(posedge core_clk);
    i_host.i2c_addr({7'h01, 1'b0}, 1'b0, ack);
    check(ack, 1'b1);
    i_host.i2c_addr({7'h03, 1'b0}, 1'b1, ack);
    check(ack, 1'b1);
    i_host.i2c_addr({7'h01, 1'b0}, 1'b1, ack);
    check(ack, 1'b0);
  endtask
  // main sequence
  initial
  begin
    reset = 1'b1;
    port_spi_mode = 1'b0;
    addr_select_lo = 1'b0;
    boot_from_eeprom_sel = 1'b0;
    boot_scl_low = 1'b0;
    boot_sda_low = 1'b0;
    t_boot();
    t_spi_write();
    t_spi_read();
    t_i2c();
    results();
  end
endmodule

/* tb/cpp_control_port_assertions.sv */
`timescale 1ns/10ps
module cpp_control_port_assertions (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pins and boot side
  input wire logic port_spi_mode,
  input wire logic spi_latch_n,
  input wire logic ctl_data_out,
  input wire logic ctl_data_oe,
  input wire logic ctl_clock_out,
  input wire logic ctl_clock_oe,
  input wire logic boot_scl_low,
  input wire logic boot_mode,
  input wire logic boot_start,
  // core access side
  input wire cpp_pkg::cpp_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic spi_frame_active
);
  import cpp_pkg::*;
  // -----------------------------
  // sequences and properties
  // -----------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // latch held high for five samples
  sequence s_latch_idle;
    spi_latch_n [*5];
  endsequence
  // spi read header handed to the core
  sequence s_spi_read_hdr;
    cmd_valid && cmd.from_spi && cmd.is_read;
  endsequence
  a_clock_out_low: assert property (ctl_clock_out == 1'b0)
    else $error("clock pin driven high");
  a_clock_oe_cause: assert property (1'b1 |=> ctl_clock_oe == $past(boot_mode && boot_scl_low))
    else $error("clock pin enable without boot request");
  a_i2c_low_only: assert property (!port_spi_mode |-> !ctl_data_out)
    else $error("data line driven high in i2c mode");
  a_spi_oe_latch: assert property (port_spi_mode && !boot_mode && spi_latch_n |-> !ctl_data_oe)
    else $error("serial output driven outside a frame");
  a_boot_pulse: assert property (boot_start |=> !boot_start)
    else $error("boot start longer than one cycle");
  a_boot_mode: assert property (boot_start |-> boot_mode)
    else $error("boot start without boot mode");
  a_frame_idle: assert property (s_latch_idle |-> !spi_frame_active)
    else $error("frame active with latch high");
  a_frame_mode: assert property (spi_frame_active |-> $past(port_spi_mode))
    else $error("frame active outside spi mode");
  a_read_fetch: assert property (s_spi_read_hdr |-> ##[0:3] rd_req)
    else $error("read header without fetch");
  a_write_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("write strobe longer than one cycle");
endmodule
bind cpp_control_port cpp_control_port_assertions i_chk (.core_clk(core_clk), .reset(reset),
  .port_spi_mode(port_spi_mode), .spi_latch_n(spi_latch_n), .ctl_data_out(ctl_data_out),
  .ctl_data_oe(ctl_data_oe), .ctl_clock_out(ctl_clock_out), .ctl_clock_oe(ctl_clock_oe),
  .boot_scl_low(boot_scl_low), .boot_mode(boot_mode), .boot_start(boot_start), .cmd(cmd),
  .cmd_valid(cmd_valid), .wr_valid(wr_valid), .rd_req(rd_req),
  .spi_frame_active(spi_frame_active));

/* tb/cpp_host_model.sv */
`timescale 1ns/10ps
module cpp_host_model (
  // pins driven by the host
  output logic spi_latch_n,
  output logic spi_serial_clock,
  output logic spi_data_in,
  output logic host_sda_low,
  // resolved data wire
  input wire logic sda_wire
);
  // idle: latch high, clock stopped
  initial
  begin
    spi_latch_n = 1'b1;
    spi_serial_clock = 1'b0;
    spi_data_in = 1'b0;
    host_sda_low = 1'b0;
  end
  // framed spi transfer, msb first, 32 ns link clock, offset from core edges
  // free: clock keeps running with latch high ahead of the frame
  task automatic spi_xfer(input int nbits, input bit free, input logic [63:0] tx,
                          output logic [63:0] rx);
    rx = '0;
    #1 spi_serial_clock = 1'b0;
    if (free)
    begin
      repeat (4)
      begin
        #16 spi_serial_clock = 1'b1;
        #16 spi_serial_clock = 1'b0;
      end
    end
    spi_latch_n = 1'b0;
    #16;
    for (int i = 0; i < nbits; i++)
    begin
      spi_data_in = tx[63 - i];
      #16 rx = {rx[62:0], sda_wire};
      spi_serial_clock = 1'b1;
      #16 spi_serial_clock = 1'b0;
    end
    #16 spi_latch_n = 1'b1;
    // clock stays stopped, released input shows no stale level
    spi_data_in = ~spi_data_in;
    #64;
  endtask
  // i2c start, address byte, ack slot, stop; strap drives address bit 1
  task automatic i2c_addr(input logic [7:0] abyte, input logic strap, output logic acked);
    spi_data_in = strap;
    #1 spi_serial_clock = 1'b1;
    #40 host_sda_low = 1'b1;
    #40 spi_serial_clock = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      host_sda_low = (i < 8) ? ~abyte[7 - i] : 1'b0;
      #40 spi_serial_clock = 1'b1;
      acked = ~sda_wire;
      #40 spi_serial_clock = 1'b0;
    end
    #40 host_sda_low = 1'b1;
    #40 spi_serial_clock = 1'b1;
    #40 host_sda_low = 1'b0;
    #80;
  endtask
endmodule
